// ---- host_model.sv ----
// Host bus model driving the burst SRAM port pins.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module host_model
	import sram_port_pkg::*;
(
	input  wire logic            clk,          // Clock
	output sram_port_pkg::ctrl_s c,            // Synchronous controls
	output sram_port_pkg::word_t data_in,      // Write data pins
	output logic                 out_enable_n, // Output enable
	output logic                 burst_mode,   // Order strap
	output logic                 sleep_request // Sleep pin
);
	initial
	begin
		c = CTRL_IDLE;
		data_in = '0;
		out_enable_n = 1'b1;
		burst_mode = MODE_LINEAR;
		sleep_request = 1'b0;
	end

	// One bus cycle; released lines toggle
	task automatic op(input logic [1:0] sel, stb, input logic adv_n, input logic [5:0] w,
		input logic [7:0] a, input word_t wd);
		@(posedge clk);
		#2;
		c.chip_sel_low_first = sel == 2'h2;
		c.chip_sel_high = sel != 2'h1;
		c.chip_sel_low_second = sel == 2'h3;
		{c.proc_addr_strobe_n, c.ctrl_addr_strobe_n} = stb;
		c.burst_advance_n = adv_n;
		{c.global_write_n, c.byte_write_enable_n, c.lane_write_sel_n} = w;
		c.addr = stb == 2'h3 ? ~c.addr : a;
		data_in = w == 6'h3F ? ~data_in : wd;
	endtask : op

	// Strap changes only between accesses
	task automatic pins(input logic oe, mode, zz);
		@(posedge clk);
		#2;
		out_enable_n = oe;
		burst_mode = mode;
		sleep_request = zz;
	endtask : pins
endmodule : host_model

// ---- sram_port_checker.sv ----
// Concurrent checks on the burst SRAM port pins.
// Assumes it is bound onto sync_burst_sram_port.
`timescale 1ns/1ps
module sram_port_checker
	import sram_port_pkg::*;
(
	input wire logic                  clk,                 // Clock
	input wire logic                  rst_n,               // Reset, low
	input wire logic                  chip_sel_low_first,  // Select 1
	input wire logic                  chip_sel_high,       // Select 2
	input wire logic                  chip_sel_low_second, // Select 3
	input wire logic                  proc_addr_strobe_n,  // Processor strobe
	input wire logic                  ctrl_addr_strobe_n,  // Controller strobe
	input wire logic                  burst_advance_n,     // Advance
	input wire logic                  global_write_n,      // Global write
	input wire logic                  byte_write_enable_n, // Byte enable
	input wire logic                  out_enable_n,        // Output enable
	input wire logic                  sleep_request,       // Sleep pin
	input wire sram_port_pkg::word_t  data_out,            // Read data
	input wire logic [LANES-1:0]      data_oe,             // Drive enables
	input wire logic                  sleeping             // Sleep state
);
	wire sel = !chip_sel_low_first && chip_sel_high && !chip_sel_low_second;
	wire rd = sel && !ctrl_addr_strobe_n && global_write_n && byte_write_enable_n && !sleep_request && !sleeping;
	wire cw = sel && !ctrl_addr_strobe_n && proc_addr_strobe_n && !global_write_n && !sleeping;
	wire ds = !chip_sel_high && !ctrl_addr_strobe_n;
	wire quiet = proc_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n && global_write_n && byte_write_enable_n;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	reset_clear_a: assert property ($rose(rst_n) |-> data_oe == 4'h0 && !sleeping)
		else $error("outputs not clear after reset");
	write_float_a: assert property (cw |-> ##2 data_oe == 4'h0)
		else $error("pins driven in write cycle");
	desel_float_a: assert property (ds |-> ##2 data_oe == 4'h0)
		else $error("pins driven after deselect");
	first_mask_a: assert property (ds ##1 rd |-> ##2 data_oe == 4'h0)
		else $error("first read after deselect driven");
	read_drive_a: assert property (!out_enable_n[*5] ##0 rd ##1 rd |-> ##2 data_oe == 4'hF)
		else $error("read data not driven");
	oe_off_a: assert property (out_enable_n[*5] |-> data_oe == 4'h0)
		else $error("pins driven with enable high");
	sleep_enter_a: assert property (sleep_request[*4] |-> sleeping && data_oe == 4'h0)
		else $error("sleep not entered");
	sleep_exit_a: assert property (!sleep_request[*4] |-> !sleeping)
		else $error("sleep not left");
	hold_out_a: assert property (quiet[*5] |-> $stable(data_out))
		else $error("read data moved without access");

	cover property (rd ##1 !burst_advance_n);
	cover property (cw);
	cover property (sleeping);
endmodule : sram_port_checker

bind sync_burst_sram_port sram_port_checker u_sram_port_checker (.clk, .rst_n, .chip_sel_low_first,
	.chip_sel_high, .chip_sel_low_second, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
	.global_write_n, .byte_write_enable_n, .out_enable_n, .sleep_request, .data_out, .data_oe, .sleeping);

// ---- sram_port_pkg.sv ----
// Shared types and constants for the synchronous burst SRAM port.
// Assumes a single 40 MHz clock and an asynchronous active-low reset.
package sram_port_pkg;

	localparam int LANES      = 4;
	localparam int LANE_BITS  = 9;
	localparam int WORD_BITS  = LANES * LANE_BITS;
	localparam int ADDR_BITS  = 8;
	localparam int DEPTH      = 1 << ADDR_BITS;
	localparam int FIFO_DEPTH = 4;

	localparam logic [1:0] BURST_START  = 2'h0;
	localparam logic [1:0] BURST_STEP   = 2'h1;
	localparam logic       MODE_LINEAR  = 1'h0;

	// One data lane: eight bits plus parity
	typedef struct packed {
		logic       lane_parity_bit;
		logic [7:0] lane_data_bits;
	} lane_s;

	typedef lane_s [LANES-1:0] word_t;

	// Registered synchronous control group
	typedef struct packed {
		logic                 chip_sel_low_first;
		logic                 chip_sel_high;
		logic                 chip_sel_low_second;
		logic                 proc_addr_strobe_n;
		logic                 ctrl_addr_strobe_n;
		logic                 burst_advance_n;
		logic                 global_write_n;
		logic                 byte_write_enable_n;
		logic [LANES-1:0]     lane_write_sel_n;
		logic [ADDR_BITS-1:0] addr;
	} ctrl_s;

	localparam ctrl_s CTRL_IDLE = '{
		chip_sel_low_first:  1'h1,
		chip_sel_high:       1'h0,
		chip_sel_low_second: 1'h1,
		proc_addr_strobe_n:  1'h1,
		ctrl_addr_strobe_n:  1'h1,
		burst_advance_n:     1'h1,
		global_write_n:      1'h1,
		byte_write_enable_n: 1'h1,
		lane_write_sel_n:    4'hF,
		addr:                8'h00
	};

	typedef enum logic [1:0] {ST_DESEL, ST_READ, ST_WRITE, ST_PWAIT} cyc_e;

endpackage : sram_port_pkg

// ---- sync_burst_sram_port.sv ----
// Device-side logic of a pipelined burst SRAM host port.
// Assumes host drives synchronous inputs on clk; oe_n, sleep and mode are pins.
//
// Behaviour
// R1 - Selected only when CS1 low, CS2 high, CS3 low
// R2 - Processor strobe ignored while first select high
// R3 - Processor strobe loads address and burst counter
// R4 - Controller strobe loads address and burst counter
// R5 - Both strobes low: processor strobe wins
// R6 - Advance low steps burst address
// R7 - Two-bit wraparound counter generates burst addresses
// R8 - Mode strap low linear, else interleaved
// R9 - Output enable low drives data pins
// R10 - First read clock after deselect stays three-stated
// R11 - Sleep input gives low power, keeps contents
// R12 - Data pins captured on rising edge
// R13 - Read data appears one clock later
// R14 - Lane is eight data plus parity
// R15 - Global write writes all four lanes
// R16 - Partial write to selected lanes with enable
// R17 - All synchronous inputs registered first
// R18 - Read data leaves through output registers
// R19 - Writes self-timed, no extra strobe
// R20 - Address sampled only on strobe while selected
// R21 - Byte enable needed with lane selects
// R22 - Linear adds one, interleaved XORs count
// R23 - Data pins three-stated during write cycles
// R24 - Each lane select controls its own lane
// R25 - Deselect three-states and starts nothing
`timescale 1ns/1ps
module sync_burst_sram_port
	import sram_port_pkg::*;
(
	input  wire logic                             clk,                 // Clock
	input  wire logic                             rst_n,               // Async reset, low
	input  wire logic                             chip_sel_low_first,  // Select 1, low
	input  wire logic                             chip_sel_high,       // Select 2, high
	input  wire logic                             chip_sel_low_second, // Select 3, low
	input  wire logic                             proc_addr_strobe_n,  // Processor strobe
	input  wire logic                             ctrl_addr_strobe_n,  // Controller strobe
	input  wire logic                             burst_advance_n,     // Burst advance
	input  wire logic                             global_write_n,      // Global write
	input  wire logic                             byte_write_enable_n, // Byte write enable
	input  wire logic [sram_port_pkg::LANES-1:0]  lane_write_sel_n,    // Per-lane selects
	input  wire logic [sram_port_pkg::ADDR_BITS-1:0] addr,             // Address
	input  wire logic                             out_enable_n,        // Async output enable
	input  wire logic                             burst_mode,          // Order strap
	input  wire logic                             sleep_request,       // Async sleep
	input  wire sram_port_pkg::word_t             data_in,             // Data pins in
	output sram_port_pkg::word_t                  data_out,            // Data pins out
	output logic [sram_port_pkg::LANES-1:0]       data_oe,             // Lane drive enables
	output logic                                  sleeping             // Sleep state
);

	// ------------------------------------------------------------
	// Input registers
	// ------------------------------------------------------------
	ctrl_s ctl_q;
	word_t din_q;
	logic  oe_s1_q;
	logic  oe_s2_q;
	logic  zz_s1_q;
	logic  zz_s2_q;
	logic  mode_s1_q;
	logic  mode_s2_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_q <= CTRL_IDLE;
			din_q <= '0;
		end
		else
		begin
			ctl_q.chip_sel_low_first  <= chip_sel_low_first; // R17
			ctl_q.chip_sel_high       <= chip_sel_high;
			ctl_q.chip_sel_low_second <= chip_sel_low_second;
			ctl_q.proc_addr_strobe_n  <= proc_addr_strobe_n;
			ctl_q.ctrl_addr_strobe_n  <= ctrl_addr_strobe_n;
			ctl_q.burst_advance_n     <= burst_advance_n;
			ctl_q.global_write_n      <= global_write_n;
			ctl_q.byte_write_enable_n <= byte_write_enable_n;
			ctl_q.lane_write_sel_n    <= lane_write_sel_n;
			ctl_q.addr                <= addr;
			din_q                     <= data_in; // R12
		end
	end

	// Asynchronous pins pass two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oe_s1_q   <= 1'h1;
			oe_s2_q   <= 1'h1;
			zz_s1_q   <= 1'h0;
			zz_s2_q   <= 1'h0;
			mode_s1_q <= 1'h1;
			mode_s2_q <= 1'h1;
		end
		else
		begin
			oe_s1_q   <= out_enable_n;
			oe_s2_q   <= oe_s1_q;
			zz_s1_q   <= sleep_request;
			zz_s2_q   <= zz_s1_q;
			mode_s1_q <= burst_mode;
			mode_s2_q <= mode_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Cycle decode
	// ------------------------------------------------------------
	logic selected;
	logic p_start;
	logic c_start;
	logic start;
	logic desel;
	logic wr_any;
	logic [LANES-1:0] lane_we;

	assign selected = !ctl_q.chip_sel_low_first && ctl_q.chip_sel_high
		&& !ctl_q.chip_sel_low_second; // R1
	assign p_start  = !ctl_q.proc_addr_strobe_n && !ctl_q.chip_sel_low_first
		&& selected && !zz_s2_q; // R2 R5 R20
	assign c_start  = !ctl_q.ctrl_addr_strobe_n && ctl_q.proc_addr_strobe_n
		&& selected && !zz_s2_q; // R5 R20
	assign start    = p_start || c_start;
	// Deselect: controller strobe, or processor strobe with CS1 low, seen while not selected
	assign desel    = (!ctl_q.ctrl_addr_strobe_n
		|| (!ctl_q.proc_addr_strobe_n && !ctl_q.chip_sel_low_first)) && !selected; // R25

	always_comb
	begin
		if (!ctl_q.global_write_n)
			lane_we = '1; // R15
		else if (!ctl_q.byte_write_enable_n)
			lane_we = ~ctl_q.lane_write_sel_n; // R16 R21 R24
		else
			lane_we = '0;
	end
	assign wr_any = |lane_we;

	// ------------------------------------------------------------
	// Address and burst counter
	// ------------------------------------------------------------
	logic [ADDR_BITS-1:0] base_q;
	logic [1:0]           start_q;
	logic [1:0]           cnt_q;
	logic [1:0]           low_bits;
	logic [ADDR_BITS-1:0] cur_addr;
	logic                 advance;
	cyc_e                 cyc_q;

	always_comb
	begin
		if (mode_s2_q == MODE_LINEAR)
			low_bits = start_q + cnt_q; // R8 R22
		else
			low_bits = start_q ^ cnt_q; // R22
	end
	assign cur_addr = {base_q[ADDR_BITS-1:2], low_bits};
	assign advance  = !start && !ctl_q.burst_advance_n && cyc_q != ST_DESEL; // R6

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			base_q  <= '0;
			start_q <= BURST_START;
			cnt_q   <= BURST_START;
		end
		else if (start)
		begin
			base_q  <= ctl_q.addr; // R3 R4
			start_q <= ctl_q.addr[1:0];
			cnt_q   <= BURST_START; // R7
		end
		else if (advance)
			cnt_q <= cnt_q + BURST_STEP; // R6 R7
	end

	// ------------------------------------------------------------
	// Cycle state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cyc_q      <= ST_DESEL;
		end
		else
		begin
			if (desel || zz_s2_q)
				cyc_q <= ST_DESEL; // R25 R11
			else if (p_start)
			begin
				cyc_q      <= ST_PWAIT; // Processor write waits a clock
			end
			else if (c_start)
			begin
				cyc_q      <= wr_any ? ST_WRITE : ST_READ;
			end
			else
			begin
				case (cyc_q)
					ST_PWAIT: cyc_q <= wr_any ? ST_WRITE : ST_READ;
					ST_READ:  cyc_q <= wr_any ? ST_WRITE : ST_READ;
					ST_WRITE: cyc_q <= wr_any ? ST_WRITE : ST_READ;
					ST_DESEL: cyc_q <= ST_DESEL;
					default:  cyc_q <= ST_DESEL;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Write path through FIFO
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LANES-1:0]     we;
		logic [ADDR_BITS-1:0] a;
		word_t                d;
	} wreq_s;

	wreq_s wr_in;
	wreq_s wr_out;
	logic  wr_push;
	logic  wr_room;
	logic  wr_avail;
	logic  wr_drain;

	// Processor write uses controls at the second clock
	assign wr_in.we = lane_we;
	assign wr_in.a  = c_start ? ctl_q.addr : cur_addr;
	assign wr_in.d  = din_q;
	assign wr_push  = wr_any && !desel && !zz_s2_q
		&& (c_start || (!p_start && cyc_q != ST_DESEL)); // R19 R25
	// Array port is idle during writes and stalls in sleep
	assign wr_drain = !zz_s2_q;

	word_fifo #(
		.WIDTH ($bits(wreq_s)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk     (clk),
		.rst_n   (rst_n),
		.i_valid (wr_push),
		.i_ready (wr_room),
		.i_data  (wr_in),
		.o_valid (wr_avail),
		.o_ready (wr_drain),
		.o_data  (wr_out)
	);

	// ------------------------------------------------------------
	// Storage array
	// ------------------------------------------------------------
	word_t mem [DEPTH];
	logic  rd_en;
	logic [ADDR_BITS-1:0] rd_addr;

	// Lane-masked store, retained while sleeping
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < LANES; i++)
		begin
			if (wr_avail && wr_drain && wr_out.we[i])
				mem[wr_out.a][i] <= wr_out.d[i]; // R14 R24 R11
		end
	end

	assign rd_en   = !wr_any && !desel && !zz_s2_q && wr_room
		&& (c_start || p_start || cyc_q == ST_READ || cyc_q == ST_PWAIT);
	assign rd_addr = start ? ctl_q.addr : cur_addr;

	// ------------------------------------------------------------
	// Output registers and drive control
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			data_out <= '0;
		else if (rd_en)
			data_out <= mem[rd_addr]; // R13 R18
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			data_oe <= '0;
		else if (oe_s2_q || desel || zz_s2_q || wr_any || !rd_en
			|| (start && cyc_q == ST_DESEL))
			data_oe <= '0; // R9 R10 R23 R25
		else
			data_oe <= '1; // R9
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sleeping <= 1'h0;
		else
			sleeping <= zz_s2_q; // R11
	end

endmodule : sync_burst_sram_port

// ---- tb_top.sv ----
// Self-checking bench for the burst SRAM port.
// Assumes host_model drives every synchronous pin.
`timescale 1ns/1ps
module tb_top;
	import sram_port_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	ctrl_s      c;
	word_t      data_in, data_out, mem [DEPTH];
	logic [3:0] data_oe;
	logic       out_enable_n, burst_mode, sleep_request, sleeping;
	int         n_fail = 0;
	int         total_checks = 0;
	int         cycles = 0;

	always #12.5 clk = ~clk;

	host_model u_host_model (.clk, .c, .data_in, .out_enable_n, .burst_mode, .sleep_request);

	sync_burst_sram_port u_sync_burst_sram_port (
		.clk, .rst_n,
		.chip_sel_low_first  (c.chip_sel_low_first),
		.chip_sel_high       (c.chip_sel_high),
		.chip_sel_low_second (c.chip_sel_low_second),
		.proc_addr_strobe_n  (c.proc_addr_strobe_n),
		.ctrl_addr_strobe_n  (c.ctrl_addr_strobe_n),
		.burst_advance_n     (c.burst_advance_n),
		.global_write_n      (c.global_write_n),
		.byte_write_enable_n (c.byte_write_enable_n),
		.lane_write_sel_n    (c.lane_write_sel_n),
		.addr                (c.addr),
		.out_enable_n, .burst_mode, .sleep_request,
		.data_in, .data_out, .data_oe, .sleeping
	);

	task automatic complete_run();
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_fail++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [35:0] exp, got);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) u_host_model.op(2'h0, 2'h3, 1'b1, 6'h3F, 8'h00, '0);
	endtask : idle

	// Processor strobe writes take a second cycle
	task automatic wr(input logic [1:0] stb, input logic [5:0] w, input logic [7:0] a, input word_t wd);
		if (stb == 2'h1)
		begin
			u_host_model.op(2'h0, stb, 1'b1, 6'h3F, a, wd);
			stb = 2'h3;
		end
		u_host_model.op(2'h0, stb, 1'b1, w, a, wd);
		for (int i = 0; i < LANES; i++)
			if (!w[5] || (!w[4] && !w[i]))
				mem[a][i] = wd[i];
	endtask : wr

	// Burst read of n words; oe is the drive expected on the first output edge
	task automatic rd(input logic [7:0] a, input int n, input logic [3:0] oe);
		logic [1:0] k;
		for (int i = 0; i < n + 3; i++)
		begin
			u_host_model.op(2'h0, i == 0 ? 2'h2 : 2'h3, i == 0 || i >= n, 6'h3F, a, '0);
			k = burst_mode ? a[1:0] ^ 2'(i - 3) : a[1:0] + 2'(i - 3);
			if (i == 2)
				check("data_oe", 36'(oe), 36'(data_oe));
			if (i >= 3)
			begin
				check("data_oe", out_enable_n ? 36'h0 : 36'hF, 36'(data_oe));
				if (!out_enable_n)
					check("data_out", mem[{a[7:2], k}], data_out);
			end
		end
	endtask : rd

	initial
	begin
		repeat (10) @(posedge clk);
		#2 rst_n = 1'b1;
		check("data_oe", 36'h0, 36'(data_oe));
		check("sleeping", 36'h0, 36'(sleeping));
		u_host_model.pins(1'b0, 1'b0, 1'b0);
		idle(4);
		wr(2'h2, 6'h1F, 8'h10, 36'h9ABCDEF01);
		rd(8'h10, 1, 4'hF);
		wr(2'h2, 6'h2A, 8'h10, 36'hFFFFFFFFF);
		rd(8'h10, 1, 4'hF);
		wr(2'h2, 6'h30, 8'h10, 36'h0);
		rd(8'h10, 1, 4'hF);
		u_host_model.op(2'h0, 2'h0, 1'b1, 6'h1F, 8'h10, 36'h0);
		idle(3);
		rd(8'h10, 1, 4'hF);
		wr(2'h1, 6'h1F, 8'h33, 36'h123456789);
		rd(8'h33, 1, 4'hF);
		for (int i = 32; i < 36; i++)
			wr(2'h2, 6'h1F, 8'(i), {4{8'(i), 1'b1}});
		rd(8'h21, 4, 4'hF);
		u_host_model.op(2'h0, 2'h2, 1'b1, 6'h3F, 8'h21, '0);
		rd(8'h23, 1, 4'hF);
		u_host_model.pins(1'b0, 1'b1, 1'b0);
		idle(4);
		rd(8'h22, 4, 4'hF);
		u_host_model.op(2'h1, 2'h2, 1'b1, 6'h3F, 8'h00, '0);
		rd(8'h10, 1, 4'h0);
		u_host_model.op(2'h2, 2'h1, 1'b1, 6'h3F, 8'h00, '0);
		rd(8'h10, 1, 4'hF);
		u_host_model.pins(1'b1, 1'b1, 1'b0);
		idle(4);
		rd(8'h10, 1, 4'h0);
		u_host_model.op(2'h1, 2'h2, 1'b1, 6'h3F, 8'h00, '0);
		u_host_model.pins(1'b0, 1'b1, 1'b1);
		idle(5);
		check("sleeping", 36'h1, 36'(sleeping));
		u_host_model.op(2'h0, 2'h2, 1'b1, 6'h1F, 8'h10, 36'h0);
		u_host_model.pins(1'b0, 1'b1, 1'b0);
		idle(5);
		check("sleeping", 36'h0, 36'(sleeping));
		rd(8'h10, 1, 4'h0);
		rd(8'h10, 1, 4'hF);
		complete_run();
	end
endmodule : tb_top

// ---- word_fifo.sv ----
// Small synchronous FIFO carrying write words to the array.
// Assumes one clock; drain side may stall.
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,     // Clock
	input  wire logic             rst_n,   // Async reset, low
	input  wire logic             i_valid, // Word offered
	output logic                  i_ready, // Room available
	input  wire logic [WIDTH-1:0] i_data,  // Word in
	output logic                  o_valid, // Word waiting
	input  wire logic             o_ready, // Drain accepts
	output logic      [WIDTH-1:0] o_data   // Word out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [PW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign i_ready = (cnt_q != (PW+1)'(DEPTH));
	assign o_valid = (cnt_q != '0);
	assign o_data  = mem[rd_q];
	assign push    = i_valid && i_ready;
	assign pop     = o_valid && o_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= i_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + PW'(1);
			if (pop)
				rd_q <= rd_q + PW'(1);
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule : word_fifo
